/* p3g_pkg.sv */
// Shared constants and types for the port 3 GPIO block
`default_nettype none
package p3g_pkg;
  localparam int P3G_AW = 18;
  // Register indices; byte address is four times the index
  localparam logic [15:0] P3G_IDX_OD_SELECT = 16'hF1C6;
  localparam logic [15:0] P3G_IDX_DATA_LATCH = 16'hFFC4;
  localparam logic [15:0] P3G_IDX_DIRECTION = 16'hFFC6;
  localparam logic [15:0] P3G_RST_OD_SELECT = 16'h0000;
  localparam logic [15:0] P3G_RST_DATA_LATCH = 16'h0000;
  localparam logic [15:0] P3G_RST_DIRECTION = 16'h0000;
  // Lines 15, 14 and 12 have no open-drain bit
  localparam logic [15:0] P3G_OD_IMPL_MASK = 16'h2FFF;
  localparam int P3G_LINE_STROBE = 12;
  localparam int P3G_LINE_NOPIN = 14;
  localparam int P3G_LINE_SYSTEM_CLOCK_OUTPUT = 15;
  localparam logic [1:0] P3G_RESP_OKAY = 2'h0;
  localparam logic [1:0] P3G_RESP_SLVERR = 2'h2;
  localparam logic [15:0] P3G_ZERO16 = 16'h0000;
  localparam logic [31:0] P3G_ZERO32 = 32'h00000000;

  typedef struct packed {
    logic [15:0] level;
    logic [15:0] enable;
  } p3g_pins_s;

  typedef enum logic [0:0] {
    P3G_WR_COLLECT = 1'b0,
    P3G_WR_RESPOND = 1'b1
  } p3g_wr_state_e;
endpackage : p3g_pkg
`default_nettype wire

/* p3g_port.sv */
// Port 3 GPIO with alternate-function pin mux and AXI4-Lite registers
//
// Overview of operation
// - Direction 0 floats the line, 1 drives.
// - Open-drain bit selects push-pull or pull-low only.
// - Lines 15, 14, 12 have no open-drain.
// - Latch bit 14 drives no pin.
// - Latch, direction, open-drain reset to zero.
// - Alternate inputs come from sampled input latch.
// - Alternate output ANDed with data latch.
// - Unused alternate outputs rest high.
// - Lines 0,2,4,5,6,7 carry alternate inputs.
// - Lines 1,3,10,12,15 carry alternate outputs.
// - Lines 8,9,11,13 are bidirectional serial lines.
// - Clock output enable forces line 15 driver.
// - Line 12 carries strobe straight after reset.
// - Strobe disabled returns line 12 to GPIO.
// - Active strobe forces line 12 driver on.
// - Bus hold returns line 12 to GPIO.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module p3g_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [p3g_pkg::P3G_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [p3g_pkg::P3G_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] pinIn,
  output p3g_pkg::p3g_pins_s pinDrive,
  input wire logic [15:0] altOut,
  output logic [15:0] altIn,
  input wire logic clockOutEnable,
  input wire logic byteHighDisable,
  input wire logic writeStrobeConfig,
  input wire logic busHold
);
  import p3g_pkg::*;

  logic [15:0] dataReg, dataNext;
  logic [15:0] dirReg, dirNext;
  logic [15:0] odReg, odNext;
  p3g_wr_state_e wrStateReg, wrStateNext;
  logic awHeldReg, awHeldNext;
  logic wHeldReg, wHeldNext;
  logic [15:0] awIdxReg, awIdxNext;
  logic [31:0] wDataReg, wDataNext;
  logic [3:0] wStrbReg, wStrbNext;
  logic awReadyReg, awReadyNext;
  logic wReadyReg, wReadyNext;
  logic bValidReg, bValidNext;
  logic [1:0] bRespReg, bRespNext;
  logic arReadyReg, arReadyNext;
  logic rValidReg, rValidNext;
  logic [31:0] rDataReg, rDataNext;
  logic [1:0] rRespReg, rRespNext;
  logic [15:0] syncOneReg, syncTwoReg, syncThreeReg;
  logic [15:0] inLatchReg, inLatchNext;
  p3g_pins_s pinReg, pinNext;
  logic strobeActive;

  function automatic logic [15:0] mergeBytes(input logic [15:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : mergeBytes

  // Register bus: write and read channels
  always_comb begin
    logic [15:0] idx;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awHave, wHave;
    idx = awIdxReg;
    wd = wDataReg;
    ws = wStrbReg;
    awHave = awHeldReg;
    wHave = wHeldReg;
    dataNext = dataReg;
    dirNext = dirReg;
    odNext = odReg;
    wrStateNext = wrStateReg;
    awHeldNext = awHeldReg;
    wHeldNext = wHeldReg;
    awIdxNext = awIdxReg;
    wDataNext = wDataReg;
    wStrbNext = wStrbReg;
    bValidNext = bValidReg;
    bRespNext = bRespReg;
    arReadyNext = arReadyReg;
    rValidNext = rValidReg;
    rDataNext = rDataReg;
    rRespNext = rRespReg;
    if (s_axi_awvalid && awReadyReg) begin
      idx = s_axi_awaddr[P3G_AW-1:2];
      awHave = 1'b1;
    end
    if (s_axi_wvalid && wReadyReg) begin
      wd = s_axi_wdata;
      ws = s_axi_wstrb;
      wHave = 1'b1;
    end
    case (wrStateReg)
      P3G_WR_COLLECT: begin
        awHeldNext = awHave;
        wHeldNext = wHave;
        awIdxNext = idx;
        wDataNext = wd;
        wStrbNext = ws;
        if (awHave && wHave) begin
          // Stored now, so the pins follow at this same edge
          bRespNext = P3G_RESP_OKAY;
          case (idx)
            P3G_IDX_DATA_LATCH: dataNext = mergeBytes(dataReg, wd, ws);
            P3G_IDX_DIRECTION: dirNext = mergeBytes(dirReg, wd, ws);
            P3G_IDX_OD_SELECT: odNext =
                mergeBytes(odReg, wd, ws) & P3G_OD_IMPL_MASK;
            default: bRespNext = P3G_RESP_SLVERR;
          endcase
          awHeldNext = 1'b0;
          wHeldNext = 1'b0;
          bValidNext = 1'b1;
          wrStateNext = P3G_WR_RESPOND;
        end
      end
      P3G_WR_RESPOND: begin
        if (s_axi_bready) begin
          bValidNext = 1'b0;
          wrStateNext = P3G_WR_COLLECT;
        end
      end
      default: wrStateNext = P3G_WR_COLLECT;
    endcase
    awReadyNext = (wrStateNext == P3G_WR_COLLECT) && !awHeldNext;
    wReadyNext = (wrStateNext == P3G_WR_COLLECT) && !wHeldNext;
    if (s_axi_arvalid && arReadyReg) begin
      arReadyNext = 1'b0;
      rValidNext = 1'b1;
      rRespNext = P3G_RESP_OKAY;
      case (s_axi_araddr[P3G_AW-1:2])
        P3G_IDX_DATA_LATCH: rDataNext = {P3G_ZERO16, dataReg};
        P3G_IDX_DIRECTION: rDataNext = {P3G_ZERO16, dirReg};
        P3G_IDX_OD_SELECT: rDataNext = {P3G_ZERO16, odReg};
        default: begin
          rDataNext = P3G_ZERO32;
          rRespNext = P3G_RESP_SLVERR;
        end
      endcase
    end else if (rValidReg && s_axi_rready) begin
      rValidNext = 1'b0;
      arReadyNext = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dataReg <= P3G_RST_DATA_LATCH;
      dirReg <= P3G_RST_DIRECTION;
      odReg <= P3G_RST_OD_SELECT;
      wrStateReg <= P3G_WR_COLLECT;
      awHeldReg <= 1'b0;
      wHeldReg <= 1'b0;
      awIdxReg <= P3G_ZERO16;
      wDataReg <= P3G_ZERO32;
      wStrbReg <= 4'h0;
      awReadyReg <= 1'b0;
      wReadyReg <= 1'b0;
      bValidReg <= 1'b0;
      bRespReg <= P3G_RESP_OKAY;
      arReadyReg <= 1'b1;
      rValidReg <= 1'b0;
      rDataReg <= P3G_ZERO32;
      rRespReg <= P3G_RESP_OKAY;
    end else begin
      dataReg <= dataNext;
      dirReg <= dirNext;
      odReg <= odNext;
      wrStateReg <= wrStateNext;
      awHeldReg <= awHeldNext;
      wHeldReg <= wHeldNext;
      awIdxReg <= awIdxNext;
      wDataReg <= wDataNext;
      wStrbReg <= wStrbNext;
      awReadyReg <= awReadyNext;
      wReadyReg <= wReadyNext;
      bValidReg <= bValidNext;
      bRespReg <= bRespNext;
      arReadyReg <= arReadyNext;
      rValidReg <= rValidNext;
      rDataReg <= rDataNext;
      rRespReg <= rRespNext;
    end
  end

  assign s_axi_awready = awReadyReg;
  assign s_axi_wready = wReadyReg;
  assign s_axi_bvalid = bValidReg;
  assign s_axi_bresp = bRespReg;
  assign s_axi_arready = arReadyReg;
  assign s_axi_rvalid = rValidReg;
  assign s_axi_rdata = rDataReg;
  assign s_axi_rresp = rRespReg;

  // Pin input sampling; filter passes a bit once stages agree
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      inLatchNext[i] = (syncTwoReg[i] == syncThreeReg[i]) ?
          syncThreeReg[i] : inLatchReg[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncOneReg <= P3G_ZERO16;
      syncTwoReg <= P3G_ZERO16;
      syncThreeReg <= P3G_ZERO16;
      inLatchReg <= P3G_ZERO16;
    end else begin
      syncOneReg <= pinIn;
      syncTwoReg <= syncOneReg;
      syncThreeReg <= syncTwoReg;
      inLatchReg <= inLatchNext;
    end
  end

  // Every peripheral sees the filtered latch; lines 0,2,4-7 input
  // only, lines 8,9,11,13 bidirectional
  assign altIn = inLatchReg;

  // Strobe selected by start-up straps unless bus hold
  assign strobeActive = (!byteHighDisable || writeStrobeConfig) &&
      !busHold;

  // Pin drivers, computed from next register values
  always_comb begin
    logic [15:0] lvl, en, od;
    // Idle alternates sit high, so latch alone rules the line
    lvl = dataNext & altOut;
    en = dirNext;
    od = odNext & P3G_OD_IMPL_MASK;
    if (clockOutEnable) begin
      lvl[P3G_LINE_SYSTEM_CLOCK_OUTPUT] = altOut[P3G_LINE_SYSTEM_CLOCK_OUTPUT];
      en[P3G_LINE_SYSTEM_CLOCK_OUTPUT] = 1'b1;
    end
    if (strobeActive) begin
      // Latch is zero after reset, so strobe bypasses it
      lvl[P3G_LINE_STROBE] = altOut[P3G_LINE_STROBE];
      en[P3G_LINE_STROBE] = 1'b1;
    end
    for (int i = 0; i < 16; i++) begin
      if (od[i]) begin
        en[i] = en[i] && !lvl[i];
        lvl[i] = 1'b0;
      end
    end
    en[P3G_LINE_NOPIN] = 1'b0;
    lvl[P3G_LINE_NOPIN] = 1'b0;
    pinNext.level = lvl;
    pinNext.enable = en;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinReg <= '{level: P3G_ZERO16, enable: P3G_ZERO16};
    end else begin
      pinReg <= pinNext;
    end
  end

  assign pinDrive = pinReg;

  property p_reset_zero;
    @(posedge sys_clk) $fell(rst) |->
      dataReg == P3G_ZERO16 && dirReg == P3G_ZERO16 && odReg == P3G_ZERO16;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not zero after reset");
  property p_input_floats;
    @(posedge sys_clk) disable iff (rst)
      !dirNext[0] |=> !pinDrive.enable[0];
  endproperty
  a_input_floats: assert property (p_input_floats)
    else $error("line 0 driven while direction is input");
  property p_open_drain_low;
    @(posedge sys_clk) disable iff (rst)
      odNext[3] |=> !pinDrive.level[3];
  endproperty
  a_open_drain_low: assert property (p_open_drain_low)
    else $error("open-drain line drives high");
  property p_no_od_bits;
    @(posedge sys_clk) disable iff (rst)
      odReg[15] == 1'b0 && odReg[14] == 1'b0 && odReg[12] == 1'b0;
  endproperty
  a_no_od_bits: assert property (p_no_od_bits)
    else $error("unimplemented open-drain bit set");
  property p_no_pin_14;
    @(posedge sys_clk) disable iff (rst)
      !pinDrive.enable[14] && !pinDrive.level[14];
  endproperty
  a_no_pin_14: assert property (p_no_pin_14)
    else $error("line 14 driven");
  property p_filter;
    @(posedge sys_clk) disable iff (rst)
      syncTwoReg[2] == syncThreeReg[2] |=>
        inLatchReg[2] == $past(syncThreeReg[2]);
  endproperty
  a_filter: assert property (p_filter)
    else $error("input latch missed agreed sample");
  property p_alt_and;
    @(posedge sys_clk) disable iff (rst)
      dirNext[1] && !odNext[1] |=>
        pinDrive.enable[1] &&
        pinDrive.level[1] == $past(dataNext[1] & altOut[1]);
  endproperty
  a_alt_and: assert property (p_alt_and)
    else $error("line 1 not latch AND alternate");
  property p_system_clock_output_driver;
    @(posedge sys_clk) disable iff (rst)
      clockOutEnable |=> pinDrive.enable[15];
  endproperty
  a_system_clock_output_driver: assert property (p_system_clock_output_driver)
    else $error("clock output driver off");
  property p_strobe_driver;
    @(posedge sys_clk) disable iff (rst)
      strobeActive |=> pinDrive.enable[12] &&
        pinDrive.level[12] == $past(altOut[12]);
  endproperty
  a_strobe_driver: assert property (p_strobe_driver)
    else $error("strobe line not driven");
  property p_hold_gpio;
    @(posedge sys_clk) disable iff (rst)
      busHold && !clockOutEnable |=>
        pinDrive.enable[12] == $past(dirNext[12]);
  endproperty
  a_hold_gpio: assert property (p_hold_gpio)
    else $error("line 12 not GPIO in bus hold");
  property p_write_to_pin;
    @(posedge sys_clk) disable iff (rst)
      wrStateReg == P3G_WR_COLLECT && wrStateNext == P3G_WR_RESPOND
        |=> s_axi_bvalid && dirReg == $past(dirNext);
  endproperty
  a_write_to_pin: assert property (p_write_to_pin)
    else $error("write not stored with response");
endmodule : p3g_port
`default_nettype wire

/* p3g_pin_env.sv */
// Pin and peripheral surroundings of the port 3 block
`timescale 1ns/1ns
`default_nettype none
module p3g_pin_env (
  input wire p3g_pkg::p3g_pins_s pinDrive,
  input wire logic [15:0] extLevel,
  input wire logic [15:0] altUse,
  input wire logic [15:0] altVal,
  output logic [15:0] pinIn,
  output logic [15:0] altOut
);
  import p3g_pkg::*;
  // Released lines follow the outside circuit, never the old drive
  assign pinIn = (pinDrive.enable & pinDrive.level) |
                 (~pinDrive.enable & extLevel);
  // Idle peripheral outputs rest high
  assign altOut = ~altUse | altVal;
endmodule : p3g_pin_env
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the port 3 GPIO block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module testbench;
  import p3g_pkg::*;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [P3G_AW-1:0] awAddr = '0;
  logic [P3G_AW-1:0] arAddr = '0;
  // Response readies stay up, so back-to-back calls never retoggle them
  logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h1;
  logic arValid = 1'h0, rReady = 1'h1;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [31:0] wData = '0;
  logic [31:0] rData;
  logic [3:0] wStrb = '0;
  logic [1:0] bResp, rResp, resp;
  logic [15:0] pinIn, altOut, altIn;
  logic [15:0] extLevel = 16'hA5C3, altUse = '0, altVal = '0;
  logic clockOutEnable = 1'h0, byteHighDisable = 1'h0;
  logic writeStrobeConfig = 1'h0, busHold = 1'h0;
  p3g_pins_s pinDrive, e;
  logic [15:0] mLat = '0, mDir = '0, mOd = '0, cur;
  logic [15:0] idxTab [4] = '{P3G_IDX_OD_SELECT, P3G_IDX_DATA_LATCH,
                              P3G_IDX_DIRECTION, 16'h1234};
  logic [31:0] d, rd;
  logic [3:0] s;
  int error_cnt = 0, checks = 0, seed = 21510, k;

  always #2 sys_clk = ~sys_clk;

  p3g_port p3g_port_i (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .pinIn(pinIn), .pinDrive(pinDrive),
    .altOut(altOut), .altIn(altIn), .clockOutEnable(clockOutEnable),
    .byteHighDisable(byteHighDisable),
    .writeStrobeConfig(writeStrobeConfig), .busHold(busHold));
  p3g_pin_env p3g_pin_env_i (.pinDrive(pinDrive), .extLevel(extLevel),
    .altUse(altUse), .altVal(altVal), .pinIn(pinIn), .altOut(altOut));

  task automatic close_out();
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic hang();
    error_cnt++;
    $display("BAD %0t bus timeout", $time);
    close_out();
  endtask : hang

  task automatic axw(input logic [15:0] i, output logic [1:0] r);
    int n;
    n = 0;
    awAddr <= {i, 2'h0};
    wData <= d;
    wStrb <= s;
    awValid <= 1'h1;
    wValid <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awValid && awReady) awValid <= 1'h0;
      if (wValid && wReady) wValid <= 1'h0;
      if (n > 50) hang();
    end while (!bValid);
    r = bResp;
  endtask : axw

  task automatic axr(input logic [15:0] i, output logic [1:0] r);
    int n;
    n = 0;
    arAddr <= {i, 2'h0};
    arValid <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arValid && arReady) arValid <= 1'h0;
      if (n > 50) hang();
    end while (!rValid);
    r = rResp;
    rd = rData;
  endtask : axr

  // Line by line drive from model registers and side inputs
  function automatic p3g_pins_s expPins();
    p3g_pins_s x;
    logic v;
    x = '0;
    for (int i = 0; i < 16; i++) begin
      v = mLat[i] & altOut[i];
      if (i == P3G_LINE_NOPIN) x.enable[i] = 1'h0;
      else if (i == P3G_LINE_STROBE && !busHold &&
               (!byteHighDisable || writeStrobeConfig)) begin
        x.enable[i] = 1'h1;
        x.level[i] = altOut[i];
      end else if (i == P3G_LINE_SYSTEM_CLOCK_OUTPUT && clockOutEnable) begin
        x.enable[i] = 1'h1;
        x.level[i] = altOut[i];
      end else if (!mDir[i]) x.enable[i] = 1'h0;
      else if (mOd[i] && P3G_OD_IMPL_MASK[i]) x.enable[i] = !v;
      else begin
        x.enable[i] = 1'h1;
        x.level[i] = v;
      end
    end
    return x;
  endfunction : expPins

  task automatic chkPins();
    e = expPins();
    `CHK(pinDrive.enable, e.enable)
    `CHK(pinDrive.level & e.enable, e.level)
  endtask : chkPins

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    for (k = 0; k < 3; k++) begin
      axr(idxTab[k], resp);
      `CHK(rd, 32'h00000000)
    end
    chkPins();
    repeat (60) begin
      {clockOutEnable, byteHighDisable, writeStrobeConfig, busHold} <=
        4'($random(seed));
      altUse <= 16'($random(seed));
      altVal <= 16'($random(seed));
      extLevel <= 16'($random(seed));
      repeat (2) @(posedge sys_clk);
      k = $random(seed) & 3;
      d = $random(seed);
      s = 4'($random(seed));
      axw(idxTab[k], resp);
      cur = k == 0 ? mOd : k == 1 ? mLat : k == 2 ? mDir : 16'h0000;
      if (s[0]) cur[7:0] = d[7:0];
      if (s[1]) cur[15:8] = d[15:8];
      if (k == 0) mOd = cur & P3G_OD_IMPL_MASK;
      if (k == 1) mLat = cur;
      if (k == 2) mDir = cur;
      `CHK(resp, k == 3 ? P3G_RESP_SLVERR : P3G_RESP_OKAY)
      chkPins();
      axr(idxTab[k], resp);
      cur = k == 0 ? mOd : k == 1 ? mLat : k == 2 ? mDir : 16'h0000;
      `CHK(rd, {16'h0000, cur})
      `CHK(resp, k == 3 ? P3G_RESP_SLVERR : P3G_RESP_OKAY)
      repeat (6) @(posedge sys_clk);
      `CHK(altIn, (e.enable & e.level) | (~e.enable & extLevel))
    end
    // Software readies alternate outputs: push-pull, direction and latch 1
    altUse <= 16'h040A;
    d = 32'h00000000;
    s = 4'h3;
    axw(idxTab[0], resp);
    d = 32'h0000FFFF;
    axw(idxTab[1], resp);
    axw(idxTab[2], resp);
    `CHK(resp, P3G_RESP_OKAY)
    mOd = '0;
    mLat = 16'hFFFF;
    mDir = 16'hFFFF;
    repeat (20) begin
      altVal <= 16'($random(seed));
      repeat (2) @(posedge sys_clk);
      chkPins();
      `CHK(pinDrive.level & 16'h040A, altVal & 16'h040A)
    end
    // Second reset in mid-run clears what was written
    rst <= 1'h1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    mLat = '0;
    mDir = '0;
    mOd = '0;
    @(posedge sys_clk);
    for (k = 0; k < 3; k++) begin
      axr(idxTab[k], resp);
      `CHK(rd, 32'h00000000)
    end
    chkPins();
    close_out();
  end
endmodule : testbench
`default_nettype wire
